// ==== aikcd_pkg.sv ====
// Shared constants, register map and carrier types for the idle and key command decoder.
package aikcd_pkg;

   // ----------------------------------------
   // Command codes
   // ----------------------------------------
   localparam logic [7:0] CMD_IDLE_A = 8'h97;
   localparam logic [7:0] CMD_IDLE_B = 8'hE3;
   localparam logic [7:0] CMD_IDLE_IMM_A = 8'h95;
   localparam logic [7:0] CMD_IDLE_IMM_B = 8'hE1;
   localparam logic [7:0] CMD_INIT_GEOM = 8'h91;
   localparam logic [7:0] CMD_KEY_MGMT = 8'hB9;
   localparam logic [7:0] FEAT_KEY_MATERIAL = 8'h80;
   localparam int FEAT_READ_BIT = 7;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_TASKFILE_LO = 8'h00;
   localparam logic [7:0] OFF_TASKFILE_HI = 8'h04;
   localparam logic [7:0] OFF_COMMAND = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_SECURITY = 8'h10;
   localparam logic [7:0] OFF_GEOMETRY = 8'h14;
   localparam logic [7:0] OFF_POWER = 8'h18;
   localparam logic [7:0] OFF_XFER = 8'h1C;
   localparam logic [7:0] OFF_DATA = 8'h20;
   localparam logic [7:0] OFF_CONFIG = 8'h24;

   // ----------------------------------------
   // Security status word bit positions
   // ----------------------------------------
   localparam int SEC_CAP_BIT = 0;
   localparam int SEC_EN_BIT = 1;
   localparam int SEC_LOCK_BIT = 2;
   localparam int SEC_FREEZE_BIT = 3;
   localparam int SEC_EXPIRE_BIT = 4;
   localparam int SEC_ENH_BIT = 5;
   localparam int SEC_LEVEL_BIT = 8;

   // ----------------------------------------
   // Reset values and timing
   // ----------------------------------------
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] COUNT_ZERO = 8'h00;
   localparam logic [8:0] FULL_SECTORS = 9'h100;
   localparam logic [8:0] WORDS_PER_SECTOR = 9'h100;
   localparam int CLK_HZ = 25_000_000;
   localparam int TIMER_UNIT_MS = 5;
   localparam int TIMER_UNIT_CYCLES = CLK_HZ / 1000 * TIMER_UNIT_MS;
   localparam int BUSY_CYCLES = 2;

   // ----------------------------------------
   // Carrier types
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] features;
      logic [7:0] sec_count;
      logic [7:0] sec_number;
      logic [7:0] cyl_low;
      logic [7:0] cyl_high;
      logic [7:0] drive_head;
   } aikcd_taskfile_t;

   typedef struct packed {
      logic level_max;
      logic enhanced_erase;
      logic expired;
      logic frozen;
      logic locked;
      logic enabled;
      logic capable;
   } aikcd_security_t;

   typedef struct packed {
      logic error;
      logic aborted;
      logic data_req;
      logic busy_flag;
   } aikcd_status_t;

endpackage

// ==== aikcd_decoder.sv ====
// Command decoder for idle, geometry and key management commands on an AHB-Lite slave.
//
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/10ps
`default_nettype none

module aikcd_decoder (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic hard_reset,
   input wire logic key_scheme_present,
   input wire logic key_read_error,
   input wire logic [15:0] key_data,
   input wire logic [7:0] unlock_fail_limit,
   output logic [38:0] host_challenge_value,
   output logic [15:0] key_sector_offset,
   output logic key_fetch,
   output logic idle_mode,
   output logic power_down,
   output logic irq
);

   // ----------------------------------------
   // State and storage
   // ----------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_BUSY = 4'b0010,
      ST_XFER = 4'b0100,
      ST_DONE = 4'b1000
   } aikcd_state_t;

   localparam logic [7:0] CMD_SEC_UNLOCK = 8'hF2;
   localparam logic [7:0] CMD_SEC_ERASE = 8'hF4;

   aikcd_state_t state_reg;
   aikcd_pkg::aikcd_taskfile_t tf_reg;
   aikcd_pkg::aikcd_status_t stat_reg;
   aikcd_pkg::aikcd_security_t sec_reg;
   logic [7:0] config_reg;
   logic [7:0] cmd_reg;
   logic [7:0] geom_sectors_reg;
   logic [3:0] geom_heads_reg;
   logic [7:0] timer_count_reg;
   logic apd_enable_reg;
   logic [23:0] tick_reg;
   logic [7:0] apd_units_reg;
   logic [1:0] busy_cnt_reg;
   logic [8:0] sectors_left_reg;
   logic [8:0] words_left_reg;
   logic [15:0] offset_reg;
   logic [15:0] data_reg;
   logic [7:0] fail_cnt_reg;
   logic idle_reg;
   logic pd_reg;
   logic irq_reg;
   logic ph_wr_reg;
   logic ph_rd_reg;
   logic [7:0] ph_addr_reg;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire bus_go = hsel & hready & htrans[1];
   wire wr_cmd = ph_wr_reg & (ph_addr_reg == aikcd_pkg::OFF_COMMAND) & state_reg == ST_IDLE;
   wire rd_data = ph_rd_reg & (ph_addr_reg == aikcd_pkg::OFF_DATA) & state_reg == ST_XFER;
   wire rd_status = ph_rd_reg & (ph_addr_reg == aikcd_pkg::OFF_STATUS);
   wire [7:0] new_cmd = hwdata[7:0];
   wire is_idle = new_cmd == aikcd_pkg::CMD_IDLE_A || new_cmd == aikcd_pkg::CMD_IDLE_B;
   wire is_idle_imm = new_cmd == aikcd_pkg::CMD_IDLE_IMM_A ||
                      new_cmd == aikcd_pkg::CMD_IDLE_IMM_B;
   wire is_geom = new_cmd == aikcd_pkg::CMD_INIT_GEOM;
   wire is_key = new_cmd == aikcd_pkg::CMD_KEY_MGMT & key_scheme_present;
   wire is_struct = is_key & ~tf_reg.features[aikcd_pkg::FEAT_READ_BIT];
   wire is_material = is_key & tf_reg.features == aikcd_pkg::FEAT_KEY_MATERIAL;
   wire is_blocked = sec_reg.expired &
                     (new_cmd == CMD_SEC_UNLOCK || new_cmd == CMD_SEC_ERASE);
   wire is_abort = ~(is_idle | is_idle_imm | is_geom | is_struct | is_material) | is_blocked;
   wire tick_wrap = tick_reg == 24'(aikcd_pkg::TIMER_UNIT_CYCLES - 1);
   wire last_word = words_left_reg == 9'h001;
   wire [15:0] sec_word;

   assign sec_word = {7'h00, sec_reg.level_max & sec_reg.enabled, 2'b00,
                      sec_reg.enhanced_erase, sec_reg.expired, sec_reg.frozen,
                      sec_reg.locked, sec_reg.enabled, sec_reg.capable};

   always_comb begin
      hrdata = 32'h0000_0000;
      case (ph_addr_reg)
         aikcd_pkg::OFF_TASKFILE_LO: hrdata = {tf_reg.cyl_low, tf_reg.sec_number,
                                               tf_reg.sec_count, tf_reg.features};
         aikcd_pkg::OFF_TASKFILE_HI: hrdata = {16'h0000, tf_reg.drive_head, tf_reg.cyl_high};
         aikcd_pkg::OFF_COMMAND: hrdata = {24'h00_0000, cmd_reg};
         aikcd_pkg::OFF_STATUS: hrdata = {28'h000_0000, stat_reg};
         aikcd_pkg::OFF_SECURITY: hrdata = {16'h0000, sec_word};
         aikcd_pkg::OFF_GEOMETRY: hrdata = {20'h0_0000, geom_heads_reg, geom_sectors_reg};
         aikcd_pkg::OFF_POWER: hrdata = {21'h00_0000, pd_reg, idle_reg,
                                         apd_enable_reg, timer_count_reg};
         aikcd_pkg::OFF_XFER: hrdata = {7'h00, sectors_left_reg, offset_reg};
         aikcd_pkg::OFF_DATA: hrdata = {16'h0000, data_reg};
         aikcd_pkg::OFF_CONFIG: hrdata = {24'h00_0000, config_reg};
         default: hrdata = 32'h0000_0000;
      endcase
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign host_challenge_value = {tf_reg.features[6:0], tf_reg.sec_count,
                                  tf_reg.sec_number, tf_reg.cyl_low, tf_reg.cyl_high};
   assign key_sector_offset = offset_reg;
   assign key_fetch = rd_data & cmd_reg == aikcd_pkg::CMD_KEY_MGMT;
   assign idle_mode = idle_reg;
   assign power_down = pd_reg;
   assign irq = irq_reg;

   // ----------------------------------------
   // Bus phase capture
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_wr_reg <= 1'b0;
         ph_rd_reg <= 1'b0;
         ph_addr_reg <= 8'h00;
      end else if (hready) begin
         ph_wr_reg <= bus_go & hwrite;
         ph_rd_reg <= bus_go & ~hwrite;
         ph_addr_reg <= haddr[7:0];
      end
   end

   // ----------------------------------------
   // Task file and configuration writes
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tf_reg <= '0;
         config_reg <= aikcd_pkg::CONFIG_RESET;
      end else begin
         if (ph_wr_reg && ph_addr_reg == aikcd_pkg::OFF_TASKFILE_LO) begin
            tf_reg.features <= hwdata[7:0];
            tf_reg.sec_count <= hwdata[15:8];
            tf_reg.sec_number <= hwdata[23:16];
            tf_reg.cyl_low <= hwdata[31:24];
         end
         if (ph_wr_reg && ph_addr_reg == aikcd_pkg::OFF_TASKFILE_HI) begin
            tf_reg.cyl_high <= hwdata[7:0];
            tf_reg.drive_head <= hwdata[15:8];
         end
         if (ph_wr_reg && ph_addr_reg == aikcd_pkg::OFF_CONFIG) begin
            config_reg <= hwdata[7:0];
         end
         if (state_reg == ST_XFER && key_read_error) begin
            tf_reg.sec_number <= offset_reg[7:0];
            tf_reg.cyl_low <= offset_reg[15:8];
         end
      end
   end

   // ----------------------------------------
   // Security state
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sec_reg <= '0;
         fail_cnt_reg <= 8'h00;
      end else begin
         sec_reg.capable <= config_reg[0];
         sec_reg.enabled <= config_reg[1];
         sec_reg.locked <= config_reg[2];
         sec_reg.frozen <= config_reg[3];
         sec_reg.enhanced_erase <= config_reg[5];
         sec_reg.level_max <= config_reg[6];
         if (hard_reset) begin
            sec_reg.expired <= 1'b0;
            fail_cnt_reg <= 8'h00;
         end else if (ph_wr_reg && ph_addr_reg == aikcd_pkg::OFF_CONFIG && hwdata[4]) begin
            fail_cnt_reg <= fail_cnt_reg + 8'h01;
            if (fail_cnt_reg + 8'h01 >= unlock_fail_limit) begin
               sec_reg.expired <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // Command engine
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_IDLE;
         stat_reg <= '0;
         cmd_reg <= 8'h00;
         geom_sectors_reg <= 8'h00;
         geom_heads_reg <= 4'h0;
         busy_cnt_reg <= 2'b00;
         sectors_left_reg <= 9'h000;
         words_left_reg <= 9'h000;
         offset_reg <= 16'h0000;
         data_reg <= 16'h0000;
         idle_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         if (rd_status) begin
            irq_reg <= 1'b0;
         end
         case (state_reg)
            ST_IDLE: begin
               if (wr_cmd) begin
                  cmd_reg <= new_cmd;
                  stat_reg <= '{error: 1'b0, aborted: 1'b0, data_req: 1'b0, busy_flag: 1'b1};
                  busy_cnt_reg <= 2'(aikcd_pkg::BUSY_CYCLES - 1);
                  state_reg <= ST_BUSY;
                  if (is_geom && !is_abort) begin
                     geom_sectors_reg <= tf_reg.sec_count;
                     geom_heads_reg <= tf_reg.drive_head[3:0];
                  end
                  if (is_material && !is_abort) begin
                     sectors_left_reg <= tf_reg.sec_count == aikcd_pkg::COUNT_ZERO ?
                                         aikcd_pkg::FULL_SECTORS : {1'b0, tf_reg.sec_count};
                     offset_reg <= {tf_reg.cyl_low, tf_reg.sec_number};
                  end
                  if (is_struct && !is_abort) begin
                     sectors_left_reg <= 9'h001;
                     offset_reg <= 16'h0000;
                  end
                  if (is_abort) begin
                     stat_reg.aborted <= 1'b1;
                  end
                  if ((is_idle || is_idle_imm) && !is_abort) begin
                     idle_reg <= 1'b1;
                  end
               end
            end
            ST_BUSY: begin
               busy_cnt_reg <= busy_cnt_reg - 2'b01;
               if (busy_cnt_reg == 2'b00) begin
                  stat_reg.busy_flag <= 1'b0;
                  if (sectors_left_reg != 9'h000 && !stat_reg.aborted) begin
                     stat_reg.data_req <= 1'b1;
                     words_left_reg <= aikcd_pkg::WORDS_PER_SECTOR;
                     data_reg <= key_data;
                     state_reg <= ST_XFER;
                  end else begin
                     stat_reg.error <= stat_reg.aborted;
                     state_reg <= ST_DONE;
                  end
               end
            end
            ST_XFER: begin
               if (key_read_error) begin
                  stat_reg <= '{error: 1'b1, aborted: 1'b0, data_req: 1'b0, busy_flag: 1'b0};
                  sectors_left_reg <= 9'h000;
                  state_reg <= ST_DONE;
               end else if (rd_data) begin
                  data_reg <= key_data;
                  words_left_reg <= words_left_reg - 9'h001;
                  if (last_word) begin
                     sectors_left_reg <= sectors_left_reg - 9'h001;
                     offset_reg <= offset_reg + 16'h0001;
                     words_left_reg <= aikcd_pkg::WORDS_PER_SECTOR;
                     if (sectors_left_reg == 9'h001) begin
                        stat_reg.data_req <= 1'b0;
                        state_reg <= ST_DONE;
                     end
                  end
               end
            end
            ST_DONE: begin
               irq_reg <= 1'b1;
               state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Automatic power down timer
   // ----------------------------------------
   // The timer only runs while idle; any command wakes the card and restarts the count.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         apd_enable_reg <= 1'b0;
         timer_count_reg <= 8'h00;
         tick_reg <= 24'h00_0000;
         apd_units_reg <= 8'h00;
         pd_reg <= 1'b0;
      end else begin
         if (wr_cmd && is_idle && !is_abort) begin
            timer_count_reg <= tf_reg.sec_count;
            apd_enable_reg <= tf_reg.sec_count != aikcd_pkg::COUNT_ZERO;
         end
         if (wr_cmd) begin
            tick_reg <= 24'h00_0000;
            apd_units_reg <= 8'h00;
            pd_reg <= 1'b0;
         end else if (apd_enable_reg && state_reg == ST_IDLE && !pd_reg) begin
            tick_reg <= tick_wrap ? 24'h00_0000 : tick_reg + 24'h00_0001;
            if (tick_wrap) begin
               apd_units_reg <= apd_units_reg + 8'h01;
               if (apd_units_reg + 8'h01 >= timer_count_reg) begin
                  pd_reg <= 1'b1;
               end
            end
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_cmd_taken;
      wr_cmd;
   endsequence
   sequence s_done_irq;
      stat_reg.busy_flag ##[1:4] irq_reg;
   endsequence

   a_idle_busy_irq: assert property (@(posedge hclk) disable iff (!hresetn)
      s_cmd_taken and is_idle and !is_abort |-> ##1 s_done_irq)
      else $error("idle did not raise busy then interrupt");
   a_timer_enable: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_cmd && is_idle && !is_abort && tf_reg.sec_count != 8'h00 |=> apd_enable_reg)
      else $error("nonzero count did not enable power down");
   a_timer_disable: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_cmd && is_idle && !is_abort && tf_reg.sec_count == 8'h00 |=> !apd_enable_reg)
      else $error("zero count left power down enabled");
   a_imm_keeps_timer: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_cmd && is_idle_imm |=> $stable(timer_count_reg) && idle_reg)
      else $error("idle immediate changed the timer");
   a_geom_load: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_cmd && is_geom |=> geom_sectors_reg == $past(tf_reg.sec_count))
      else $error("geometry sectors not taken from count");
   a_material_count: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_cmd && is_material && !is_abort && tf_reg.sec_count == 8'h00
      |=> sectors_left_reg == 9'h100)
      else $error("zero count did not mean 256 sectors");
   a_abort_no_data: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_cmd && is_abort |=> !stat_reg.data_req [*3] ##1 stat_reg.error)
      else $error("aborted command moved data");
   a_expire_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
      sec_reg.expired && !hard_reset |=> sec_reg.expired)
      else $error("expire cleared without hard reset");
   a_level_bit: assert property (@(posedge hclk) disable iff (!hresetn)
      sec_word[8] |-> sec_reg.enabled && sec_reg.level_max)
      else $error("level bit set without enabled maximum");

endmodule // aikcd_decoder

`default_nettype wire

// ==== aikcd_keystore.sv ====
// Key store model that feeds data words and read faults to the decoder.
`timescale 1ns/10ps
`default_nettype none
module aikcd_keystore #(
   parameter logic [15:0] ERR_OFFSET = 16'h0000
) (
   input wire logic hclk,
   input wire logic key_fetch,
   input wire logic [15:0] key_sector_offset,
   input wire logic fail_arm,
   output logic [15:0] key_data,
   output logic key_read_error
);
   logic [7:0] word_reg = 8'h00;
   // A fresh word per fetch, so a decoder that never refetches shows stale data.
   always @(posedge hclk) begin
      if (key_fetch === 1'b1) begin
         word_reg <= word_reg + 8'h01;
      end
   end
   assign key_data = {key_sector_offset[7:0], word_reg};
   assign key_read_error = fail_arm && (key_sector_offset == ERR_OFFSET);
endmodule // aikcd_keystore
`default_nettype wire

// ==== aikcd_decoder_tb.sv ====
// Self-checking bench for the idle, geometry and key command decoder.
`timescale 1ns/10ps
`default_nettype none
module aikcd_decoder_tb;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hard_reset = 1'b0;
   logic scheme = 1'b1, fail_arm = 1'b0, hreadyout, hresp, key_read_error, key_fetch;
   logic idle_mode, power_down, irq;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, st;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [7:0] limit = 8'h02;
   logic [15:0] key_data, key_sector_offset;
   logic [38:0] chal;
   int n_mismatch = 0, check_count = 0, fetches = 0;
   always #20 hclk = ~hclk;
   always @(posedge hclk) if (key_fetch === 1'b1) fetches <= fetches + 1;
   aikcd_decoder u_aikcd_decoder (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .hard_reset(hard_reset),
      .key_scheme_present(scheme), .key_read_error(key_read_error), .key_data(key_data),
      .unlock_fail_limit(limit), .host_challenge_value(chal),
      .key_sector_offset(key_sector_offset), .key_fetch(key_fetch), .idle_mode(idle_mode),
      .power_down(power_down), .irq(irq));
   aikcd_keystore #(.ERR_OFFSET(16'h1235)) u_aikcd_keystore (.hclk(hclk), .key_fetch(key_fetch),
      .key_sector_offset(key_sector_offset), .fail_arm(fail_arm), .key_data(key_data),
      .key_read_error(key_read_error));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
         n_mismatch++;
      end
   endtask
   // One single-word transfer; both phases are held until hready is seen high.
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("hresp", 0, hresp);
   endtask
   task wait_st();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 60) begin
         @(posedge hclk);
         n++;
      end
      chk("irq", 1, irq);
      ahb(0, aikcd_pkg::OFF_STATUS, 0);
      st = rd;
   endtask
   task cmd_go(input logic [31:0] lo, input logic [15:0] hi, input logic [7:0] c);
      ahb(1, aikcd_pkg::OFF_TASKFILE_LO, lo);
      ahb(1, aikcd_pkg::OFF_TASKFILE_HI, {16'h0, hi});
      ahb(1, aikcd_pkg::OFF_COMMAND, {24'h0, c});
   endtask
   task cmd(input logic [31:0] lo, input logic [15:0] hi, input logic [7:0] c);
      cmd_go(lo, hi, c);
      wait_st();
   endtask
   // Data commands raise no interrupt until the end, so STATUS is polled until busy drops.
   task cmd_data(input logic [31:0] lo, input logic [15:0] hi, input logic [7:0] c);
      int n;
      n = 0;
      cmd_go(lo, hi, c);
      st = 32'h1;
      while (st[0] !== 1'b0 && n < 20) begin
         ahb(0, aikcd_pkg::OFF_STATUS, 0);
         st = rd;
         n++;
      end
   endtask
   task read_words(input int n);
      fetches = 0;
      for (int i = 0; i < n; i++) ahb(0, aikcd_pkg::OFF_DATA, 0);
      // The last fetch is counted at the closing edge, so look once it has settled.
      @(negedge hclk);
      chk("fetch count", n, fetches);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_security();
      ahb(1, aikcd_pkg::OFF_CONFIG, 32'h6F);
      ahb(0, aikcd_pkg::OFF_SECURITY, 0);
      chk("security max", 32'h12F, rd);
      ahb(1, aikcd_pkg::OFF_CONFIG, 32'h03);
      ahb(0, aikcd_pkg::OFF_SECURITY, 0);
      chk("security high", 32'h003, rd);
      ahb(0, 8'h80, 0);
      chk("unmapped", 32'h0, rd);
   endtask
   task t_expire();
      ahb(1, aikcd_pkg::OFF_CONFIG, 32'h13);
      ahb(1, aikcd_pkg::OFF_CONFIG, 32'h13);
      ahb(0, aikcd_pkg::OFF_SECURITY, 0);
      chk("expired", 32'h013, rd);
      cmd(32'h0, 16'h0, 8'hF2);
      chk("unlock aborted", 32'h4, st & 32'h4);
      cmd(32'h0, 16'h0, 8'hF4);
      chk("erase aborted", 32'hC, st);
      @(posedge hclk) hard_reset <= 1'b1;
      @(posedge hclk) hard_reset <= 1'b0;
      ahb(0, aikcd_pkg::OFF_SECURITY, 0);
      chk("expire cleared", 32'h003, rd);
   endtask
   task t_idle();
      chk("idle before", 0, idle_mode);
      cmd(32'h0300, 16'h0, aikcd_pkg::CMD_IDLE_A);
      chk("idle status", 0, st);
      chk("idle mode", 1, idle_mode);
      ahb(0, aikcd_pkg::OFF_POWER, 0);
      chk("timer on", 32'h303, rd);
      cmd(32'h0000, 16'h0, aikcd_pkg::CMD_IDLE_B);
      ahb(0, aikcd_pkg::OFF_POWER, 0);
      chk("timer off", 32'h200, rd);
      cmd(32'h0700, 16'h0, aikcd_pkg::CMD_IDLE_IMM_A);
      ahb(0, aikcd_pkg::OFF_POWER, 0);
      chk("imm keeps off", 32'h200, rd);
      cmd(32'h0500, 16'h0, aikcd_pkg::CMD_IDLE_B);
      cmd(32'h0900, 16'h0, aikcd_pkg::CMD_IDLE_IMM_B);
      chk("imm status", 0, st);
      ahb(0, aikcd_pkg::OFF_POWER, 0);
      chk("imm keeps on", 32'h305, rd);
      chk("power down", 0, power_down);
   endtask
   task t_geom();
      cmd(32'hEEDD_3FCC, 16'hA7BB, aikcd_pkg::CMD_INIT_GEOM);
      ahb(0, aikcd_pkg::OFF_GEOMETRY, 0);
      chk("geometry", 32'h73F, rd);
   endtask
   task t_struct();
      cmd_data(32'hC3B2_A17F, 16'h00D4, aikcd_pkg::CMD_KEY_MGMT);
      chk("challenge", 32'hA1B2C3D4, chal[31:0]);
      chk("challenge top", 32'h7F, {25'h0, chal[38:32]});
      chk("struct accept", 32'h2, st);
      read_words(256);
      wait_st();
      chk("struct done", 0, st);
   endtask
   task t_keying();
      cmd_data(32'h1234_0080, 16'h0, aikcd_pkg::CMD_KEY_MGMT);
      chk("keying accept", 32'h2, st);
      ahb(0, aikcd_pkg::OFF_XFER, 0);
      chk("xfer start", 32'h0100_1234, rd);
      fail_arm <= 1'b1;
      read_words(256);
      wait_st();
      fail_arm <= 1'b0;
      chk("read error", 32'h8, st & 32'h8);
      ahb(0, aikcd_pkg::OFF_TASKFILE_LO, 0);
      chk("fail offset", 32'h1235, {16'h0, rd[31:16]});
   endtask
   task t_noscheme();
      scheme <= 1'b0;
      cmd(32'h0, 16'h0, aikcd_pkg::CMD_KEY_MGMT);
      chk("no scheme", 32'h4, st & 32'h6);
      scheme <= 1'b1;
   endtask
   // ----------------------------------------
   // Sequence and verdict
   // ----------------------------------------
   task wrap_up();
      $display("mismatches %0d of %0d checks", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_security();
      t_expire();
      t_idle();
      t_geom();
      t_struct();
      t_keying();
      t_noscheme();
      wrap_up();
   end
   // The run needs about 1800 cycles; the watchdog, at 30000 cycles, allows over sixteen times that.
   initial begin
      #1200000;
      n_mismatch++;
      wrap_up();
   end
endmodule // aikcd_decoder_tb
`default_nettype wire
